// [logic/doa_pkg.sv]
// constants, opcodes and register map for the double operand alu
package doa_pkg;
    localparam int          APB_W        = 32;
    localparam int          ADDR_W       = 8;
    // instruction layout
    localparam int          BYTE_BIT     = 15;
    localparam int          OPC_HI       = 14;
    localparam int          OPC_LO       = 12;
    localparam int          SUBOP_HI     = 11;
    localparam int          SUBOP_LO     = 9;
    localparam int          REG_HI       = 8;
    localparam int          REG_LO       = 6;
    localparam logic [2:0]  OPC_CMP      = 3'h2;
    localparam logic [2:0]  OPC_BIT      = 3'h3;
    localparam logic [2:0]  OPC_BIC      = 3'h4;
    localparam logic [2:0]  OPC_BIS      = 3'h5;
    localparam logic [2:0]  OPC_SUB      = 3'h6;
    localparam logic [2:0]  OPC_REGDST   = 3'h7;
    localparam logic [2:0]  SUB_MUL      = 3'h0;
    localparam logic [2:0]  SUB_DIV      = 3'h1;
    localparam logic [2:0]  SUB_XOR      = 3'h4;
    // multiply carry bounds, upper bound as printed
    localparam int          MUL_LO       = -32768;
    localparam int          MUL_HI       = 32767;
    // largest quotient magnitudes
    localparam logic [31:0] QMAX_POS     = 32'h0000_7fff;
    localparam logic [31:0] QMAX_NEG     = 32'h0000_8000;
    localparam int          DIV_STEPS    = 32;
    // register byte offsets
    localparam logic [7:0]  OFF_INSTR    = 8'h00;
    localparam logic [7:0]  OFF_SRC      = 8'h04;
    localparam logic [7:0]  OFF_DST      = 8'h08;
    localparam logic [7:0]  OFF_PAIR     = 8'h0c;
    localparam logic [7:0]  OFF_FLAGS    = 8'h10;
    localparam logic [7:0]  OFF_RESULT   = 8'h14;
    localparam logic [7:0]  OFF_RES_PAIR = 8'h18;
    localparam logic [7:0]  OFF_STATUS   = 8'h1c;
    // flag positions
    localparam int          FLG_C        = 0;
    localparam int          FLG_V        = 1;
    localparam int          FLG_Z        = 2;
    localparam int          FLG_N        = 3;
    localparam logic [3:0]  FLAGS_RST    = 4'h0;
    typedef enum logic [3:0] {
        OP_NONE, OP_SUB, OP_CMP, OP_MUL, OP_DIV, OP_XOR, OP_BIS, OP_BIT, OP_BIC
    } doa_op_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DIV  = 2'b10
    } doa_state_e;
endpackage : doa_pkg

// [logic/doa_divider.sv]
// sequential unsigned 32 by 16 divider on magnitudes
`timescale 1ns/1ps
`default_nettype none
module doa_divider
    import doa_pkg::*;
#(
    parameter int STEPS = DIV_STEPS
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    output var  logic        done,
    output var  logic [31:0] quotient,
    output var  logic [15:0] remainder
);
    logic [15:0] dvs;
    logic [5:0]  cnt;
    logic        busy;
    logic [16:0] trial;
    logic        fits;
    logic [16:0] next_rem;

    // one restoring step per clock
    assign trial    = {remainder, quotient[31]};
    assign fits     = trial >= {1'b0, dvs};
    assign next_rem = fits ? trial - {1'b0, dvs} : trial;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dvs       <= 16'h0000;
            cnt       <= 6'h00;
            busy      <= 1'b0;
            done      <= 1'b0;
            quotient  <= 32'h0000_0000;
            remainder <= 16'h0000;
        end else if (start) begin
            dvs       <= divisor;
            quotient  <= dividend;
            remainder <= 16'h0000;
            cnt       <= 6'(STEPS - 1);
            busy      <= 1'b1;
            done      <= 1'b0;
        end else if (busy) begin
            quotient  <= {quotient[30:0], fits};
            remainder <= next_rem[15:0];
            cnt       <= cnt - 6'h01;
            busy      <= cnt != 6'h00;
            done      <= cnt == 6'h00;
        end else begin
            done      <= 1'b0;
        end
    end
endmodule : doa_divider
`default_nettype wire

// [logic/doa_alu.sv]
// double operand alu datapath with apb register access
// Operation
// - subtract forms destination minus source, result to destination, source kept
// - subtract sets negative when result below zero, zero when result zero
// - subtract overflow when operand signs differ and result sign equals source
// - subtract and compare set carry when no carry out, meaning borrow
// - compare forms source plus inverted destination plus one, flags only
// - compare overflow when signs differ and result sign equals destination
// - multiply signed; even register gets 32-bit product across register pair
// - multiply into odd register stores only low 16 product bits
// - multiply negative and zero from product, overflow always cleared
// - multiply carry when product below -2^15 or at least 2^15-1
// - divide 32-bit pair by source, quotient to even, remainder successor
// - divide remainder takes the sign of the dividend
// - divide sets overflow and aborts on zero source or quotient too big
// - divide carry on divide by zero; negative and zero from quotient
// - exclusive or into destination; nz from result, v cleared, c kept
// - or mask sets source bits in destination; nz, v cleared, c kept
// - mask test ands operands for flags only; v cleared, c kept
// - clear mask clears destination bits set in source; v cleared, c kept
// - byte bit 15, opcode 14..12, sub-opcode 11..9, destination register 8..6
`timescale 1ns/1ps
`default_nettype none
module doa_alu
    import doa_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [APB_W-1:0]  pwdata,
    output var  logic [APB_W-1:0]  prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    output var  logic              wb_dst_we,
    output var  logic              wb_pair_we,
    output var  logic [2:0]        wb_dst_reg,
    output var  logic [2:0]        pair_successor_register,
    output var  logic [15:0]       wb_dst_data,
    output var  logic [15:0]       wb_pair_data,
    output var  logic [3:0]        cond_flags
);
    // instruction decode
    function automatic doa_op_e doa_decode(input logic [15:0] w);
        doa_op_e op;
        op = OP_NONE;
        case (w[OPC_HI:OPC_LO])
            OPC_SUB: op = w[BYTE_BIT] ? OP_SUB : OP_NONE;
            OPC_CMP: op = OP_CMP;
            OPC_BIS: op = OP_BIS;
            OPC_BIT: op = OP_BIT;
            OPC_BIC: op = OP_BIC;
            OPC_REGDST: begin
                if (w[BYTE_BIT]) begin
                    op = OP_NONE;
                end else if (w[SUBOP_HI:SUBOP_LO] == SUB_MUL) begin
                    op = OP_MUL;
                end else if (w[SUBOP_HI:SUBOP_LO] == SUB_DIV) begin
                    op = OP_DIV;
                end else if (w[SUBOP_HI:SUBOP_LO] == SUB_XOR) begin
                    op = OP_XOR;
                end else begin
                    op = OP_NONE;
                end
            end
            default: op = OP_NONE;
        endcase
        return op;
    endfunction : doa_decode

    // negative and zero of a word or byte result
    function automatic logic [1:0] doa_nz(input logic [15:0] r, input logic b);
        logic n;
        logic z;
        n = b ? r[7] : r[15];
        z = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
        return {n, z};
    endfunction : doa_nz

    logic [15:0] instr;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] pair;
    logic        go;
    logic        illegal;
    logic        done;
    logic        div_start;
    logic        q_neg;
    logic        dvd_neg;
    doa_state_e  state;

    // apb decode
    wire logic       acc_edge  = psel && penable && pready;
    wire logic       wr_edge   = acc_edge && pwrite;
    wire logic       hit_instr = paddr == OFF_INSTR;
    wire logic       hit_src   = paddr == OFF_SRC;
    wire logic       hit_dst   = paddr == OFF_DST;
    wire logic       hit_pair  = paddr == OFF_PAIR;
    wire logic       hit_flags = paddr == OFF_FLAGS;
    wire logic       hit_res   = paddr == OFF_RESULT;
    wire logic       hit_resp  = paddr == OFF_RES_PAIR;
    wire logic       hit_stat  = paddr == OFF_STATUS;
    wire logic       mapped    = hit_instr | hit_src | hit_dst | hit_pair | hit_flags
                                 | hit_res | hit_resp | hit_stat;
    wire logic       busy      = go || (state == ST_DIV);
    wire logic       start_wr  = wr_edge && hit_instr && !busy;

    // operand fields
    wire doa_op_e    op        = doa_decode(instr);
    wire logic       byte_op   = instr[BYTE_BIT];
    wire logic [2:0] reg_num   = instr[REG_HI:REG_LO];
    wire logic [2:0] reg_succ  = reg_num | 3'h1;
    wire logic       reg_even  = !reg_num[0];
    wire logic       c_in      = cond_flags[FLG_C];

    // subtract
    wire logic [16:0] sub_sum  = {1'b0, dst} + {1'b0, ~src} + 17'h0_0001;
    wire logic [15:0] sub_res  = sub_sum[15:0];
    wire logic        sub_v    = (dst[15] ^ src[15]) && (sub_res[15] == src[15]);
    wire logic        sub_c    = !sub_sum[16];

    // compare
    wire logic [16:0] cmpw_sum = {1'b0, src} + {1'b0, ~dst} + 17'h0_0001;
    wire logic [8:0]  cmpb_sum = {1'b0, src[7:0]} + {1'b0, ~dst[7:0]} + 9'h001;
    wire logic [15:0] cmp_res  = byte_op ? {8'h00, cmpb_sum[7:0]} : cmpw_sum[15:0];
    wire logic        cmp_sgn  = byte_op ? cmp_res[7] : cmp_res[15];
    wire logic        src_sgn  = byte_op ? src[7] : src[15];
    wire logic        dst_sgn  = byte_op ? dst[7] : dst[15];
    wire logic        cmp_v    = (src_sgn ^ dst_sgn) && (cmp_sgn == dst_sgn);
    wire logic        cmp_c    = byte_op ? !cmpb_sum[8] : !cmpw_sum[16];

    // multiply
    wire logic signed [31:0] prod = $signed(dst) * $signed(src);
    wire logic        mul_c    = (prod < MUL_LO) || (prod >= MUL_HI);
    wire logic [15:0] mul_r    = reg_even ? prod[31:16] : prod[15:0];

    // logical group
    wire logic [15:0] xor_res  = src ^ dst;
    wire logic [15:0] bis_res  = src | dst;
    wire logic [15:0] bit_res  = src & dst;
    wire logic [15:0] bic_res  = ~src & dst;
    wire logic [15:0] hi_keep  = {dst[15:8], 8'h00};

    // divide magnitudes and signed results
    wire logic [31:0] dividend = {dst, pair};
    wire logic [31:0] dvd_mag  = dst[15] ? 32'(-dividend) : dividend;
    wire logic [15:0] dvs_mag  = src[15] ? 16'(-src) : src;
    wire logic        dvs_zero = src == 16'h0000;
    wire logic        div_done;
    wire logic [31:0] q_mag;
    wire logic [15:0] r_mag;
    wire logic        div_ovf  = q_mag > (q_neg ? QMAX_NEG : QMAX_POS);
    wire logic [15:0] quot     = q_neg ? 16'(-q_mag[15:0]) : q_mag[15:0];
    wire logic [15:0] remd     = dvd_neg ? 16'(-r_mag) : r_mag;

    doa_divider #(
        .STEPS     (DIV_STEPS)
    ) u_divider (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (div_start),
        .dividend  (dvd_mag),
        .divisor   (dvs_mag),
        .done      (div_done),
        .quotient  (q_mag),
        .remainder (r_mag)
    );

    // one-cycle operation outcome
    logic [15:0] next_dst_data;
    logic [15:0] next_pair_data;
    logic        next_dst_we;
    logic        next_pair_we;
    logic [3:0]  next_flags;
    always_comb begin
        next_dst_data  = 16'h0000;
        next_pair_data = 16'h0000;
        next_dst_we    = 1'b0;
        next_pair_we   = 1'b0;
        next_flags     = cond_flags;
        case (op)
            OP_SUB: begin
                next_dst_data = sub_res;
                next_dst_we   = 1'b1;
                next_flags    = {doa_nz(sub_res, 1'b0), sub_v, sub_c};
            end
            OP_CMP: next_flags = {doa_nz(cmp_res, byte_op), cmp_v, cmp_c};
            OP_MUL: begin
                next_dst_data  = mul_r;
                next_pair_data = prod[15:0];
                next_dst_we    = 1'b1;
                next_pair_we   = reg_even;
                next_flags     = {prod[31], prod == 32'h0000_0000, 1'b0, mul_c};
            end
            OP_DIV: begin
                next_flags = {cond_flags[FLG_N], cond_flags[FLG_Z], 1'b1, 1'b1};
            end
            OP_XOR: begin
                next_dst_data = xor_res;
                next_dst_we   = 1'b1;
                next_flags    = {doa_nz(xor_res, 1'b0), 1'b0, c_in};
            end
            OP_BIS: begin
                next_dst_data = byte_op ? (hi_keep | {8'h00, bis_res[7:0]}) : bis_res;
                next_dst_we   = 1'b1;
                next_flags    = {doa_nz(bis_res, byte_op), 1'b0, c_in};
            end
            OP_BIT: next_flags = {doa_nz(bit_res, byte_op), 1'b0, c_in};
            OP_BIC: begin
                next_dst_data = byte_op ? (hi_keep | {8'h00, bic_res[7:0]}) : bic_res;
                next_dst_we   = 1'b1;
                next_flags    = {doa_nz(bic_res, byte_op), 1'b0, c_in};
            end
            default: next_flags = cond_flags;
        endcase
    end

    wire logic finish_now = go && !(op == OP_DIV && !dvs_zero);
    wire logic finish_div = (state == ST_DIV) && div_done;
    wire logic [3:0] div_flags = div_ovf ? {cond_flags[FLG_N], cond_flags[FLG_Z], 2'b10}
                                         : {doa_nz(quot, 1'b0), 2'b00};

    // sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            go        <= 1'b0;
            div_start <= 1'b0;
            q_neg     <= 1'b0;
            dvd_neg   <= 1'b0;
        end else begin
            div_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    go <= start_wr;
                    if (go && !finish_now) begin
                        div_start <= 1'b1;
                        q_neg     <= dst[15] ^ src[15];
                        dvd_neg   <= dst[15];
                        state     <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    go <= 1'b0;
                    if (div_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // results and flags, completion beats a flag write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_dst_we    <= 1'b0;
            wb_pair_we   <= 1'b0;
            wb_dst_data  <= 16'h0000;
            wb_pair_data <= 16'h0000;
            cond_flags   <= FLAGS_RST;
            done         <= 1'b0;
            illegal      <= 1'b0;
        end else begin
            wb_dst_we  <= 1'b0;
            wb_pair_we <= 1'b0;
            if (finish_now) begin
                wb_dst_we    <= next_dst_we;
                wb_pair_we   <= next_pair_we;
                wb_dst_data  <= next_dst_data;
                wb_pair_data <= next_pair_data;
                cond_flags   <= next_flags;
                illegal      <= op == OP_NONE;
                done         <= 1'b1;
            end else if (finish_div) begin
                wb_dst_we    <= !div_ovf;
                wb_pair_we   <= !div_ovf;
                wb_dst_data  <= quot;
                wb_pair_data <= remd;
                cond_flags   <= div_flags;
                illegal      <= 1'b0;
                done         <= 1'b1;
            end else begin
                if (wr_edge && hit_flags) begin
                    cond_flags <= pwdata[3:0];
                end
                if (start_wr) begin
                    done <= 1'b0;
                end
            end
        end
    end

    // operand registers and register numbers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr                   <= 16'h0000;
            src                     <= 16'h0000;
            dst                     <= 16'h0000;
            pair                    <= 16'h0000;
            wb_dst_reg              <= 3'h0;
            pair_successor_register <= 3'h1;
        end else begin
            if (start_wr) begin
                instr <= pwdata[15:0];
            end
            if (wr_edge && hit_src && !busy) begin
                src <= pwdata[15:0];
            end
            if (wr_edge && hit_dst && !busy) begin
                dst <= pwdata[15:0];
            end
            if (wr_edge && hit_pair && !busy) begin
                pair <= pwdata[15:0];
            end
            wb_dst_reg              <= reg_num;
            pair_successor_register <= reg_succ;
        end
    end

    // apb answer, one wait-free access phase
    wire logic [APB_W-1:0] status_word = {21'h00_0000, pair_successor_register,
                                          1'b0, wb_dst_reg, 1'b0, illegal, done, busy};
    wire logic [APB_W-1:0] rd_mux =
        hit_instr ? {16'h0000, instr} :
        hit_src   ? {16'h0000, src} :
        hit_dst   ? {16'h0000, dst} :
        hit_pair  ? {16'h0000, pair} :
        hit_flags ? {28'h000_0000, cond_flags} :
        hit_res   ? {16'h0000, wb_dst_data} :
        hit_resp  ? {16'h0000, wb_pair_data} :
        hit_stat  ? status_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end
endmodule : doa_alu
`default_nettype wire

// [tb/doa_alu_properties.sv]
// port assertions for the double operand alu
`timescale 1ns/1ps
`default_nettype none
module doa_alu_properties
    import doa_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [APB_W-1:0]  pwdata,
    input wire logic [APB_W-1:0]  prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              wb_dst_we,
    input wire logic              wb_pair_we,
    input wire logic [2:0]        wb_dst_reg,
    input wire logic [2:0]        pair_successor_register,
    input wire logic [15:0]       wb_dst_data,
    input wire logic [15:0]       wb_pair_data,
    input wire logic [3:0]        cond_flags
);
    logic [15:0] op_q;
    wire         instr_wr = psel && penable && pready && pwrite && paddr == OFF_INSTR;
    wire [2:0]   sub_q    = op_q[11:9];
    wire         is_rd    = op_q[15:12] == 4'h7;
    wire         is_mul   = is_rd && sub_q == SUB_MUL;
    wire         is_lg    = (is_rd && sub_q == SUB_XOR) || op_q[14:12] == OPC_BIS
                            || op_q[14:12] == OPC_BIC;
    wire         byt      = op_q[15] && op_q[14:12] != OPC_SUB;
    wire [2:0]   wop      = pwdata[14:12];
    wire         dst_op   = wop == OPC_BIC || wop == OPC_BIS || pwdata[15:12] == 4'he
                            || (pwdata[15:12] == 4'h7 && pwdata[11:9] == SUB_MUL)
                            || (pwdata[15:12] == 4'h7 && pwdata[11:9] == SUB_XOR);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) op_q <= 16'h0000;
        else if (instr_wr) op_q <= pwdata[15:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_dst_wr; instr_wr && dst_op; endsequence
    sequence s_flag_wr; instr_wr && (wop == OPC_CMP || wop == OPC_BIT); endsequence
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_unmapped_err: assert property (pready |-> pslverr == (|paddr[1:0] || paddr > OFF_STATUS))
        else $error("bad error response");
    a_succ_reg: assert property (pair_successor_register == (wb_dst_reg | 3'h1))
        else $error("bad successor");
    a_pair_even: assert property (wb_pair_we |-> wb_dst_we && !wb_dst_reg[0])
        else $error("odd pair write");
    a_v_cleared: assert property (wb_dst_we && (is_mul || is_lg) |-> !cond_flags[FLG_V])
        else $error("overflow not cleared");
    a_nz_result: assert property (wb_dst_we && !is_mul && (!is_rd || sub_q == SUB_XOR)
        |-> cond_flags[FLG_N] == (byt ? wb_dst_data[7] : wb_dst_data[15]) && cond_flags[FLG_Z]
        == (byt ? wb_dst_data[7:0] == 8'h00 : wb_dst_data == 16'h0000))
        else $error("nz flags wrong");
    a_write_after: assert property (s_dst_wr |-> !wb_dst_we [*2] ##1 wb_dst_we)
        else $error("no dst write");
    a_flags_only: assert property (s_flag_wr |-> ##1 !wb_dst_we [*3])
        else $error("flag op wrote dst");
endmodule : doa_alu_properties
`default_nettype wire

// [tb/testbench.sv]
// self-checking testbench for the double operand alu
`timescale 1ns/1ps
`default_nettype none
module testbench
    import doa_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [APB_W-1:0]  pwdata, prdata;
    logic              pready, pslverr, wb_dst_we, wb_pair_we;
    logic [2:0]        wb_dst_reg, pair_successor_register;
    logic [15:0]       wb_dst_data, wb_pair_data, i;
    logic [3:0]        cond_flags;
    int                fails = 0;
    int                tests_run = 0;
    logic [31:0]       rq[$];
    logic [15:0]       wq[$];
    logic [63:0]       dir[14] = '{64'he000_1249_14e5_0000, 64'he000_0001_8000_0000,
        64'he000_0001_0000_0000, 64'h2000_1234_1234_0000, 64'h2000_8000_0001_0000,
        64'ha000_0080_0001_0000, 64'h7040_7fff_0001_0000, 64'h7000_8000_0001_0000,
        64'h7000_ffff_8000_0000, 64'h7200_0002_0000_2001, 64'h7200_0000_0005_0000,
        64'h7200_0001_0001_0000, 64'h7200_0002_ffff_fff9, 64'h7200_ffff_0000_8000};
    logic [15:0]       ops[12] = '{16'he000, 16'h2000, 16'ha000, 16'h3000, 16'hb000, 16'h4000,
        16'hc000, 16'h5000, 16'hd000, 16'h7000, 16'h7200, 16'h7800};
    doa_alu u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wb_dst_we, .wb_pair_we, .wb_dst_reg, .pair_successor_register,
        .wb_dst_data, .wb_pair_data, .cond_flags);
    always #2 pclk = ~pclk;
    task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t read %h exp %h", $time, got, exp);
        end
    endtask : cmp_read
    task automatic cmp_wb(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t writeback %h exp %h", $time, got, exp);
        end
    endtask : cmp_wb
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            cmp_read(prdata, rq.size() > 0 ? rq.pop_front() : 32'hxxxx_xxxx);
        if (wb_dst_we === 1'b1)
            cmp_wb(wb_dst_data, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff (pready === 1'b1));
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    function automatic void ref_op(input logic [15:0] i, s, d, p, input logic [3:0] f,
        output logic [15:0] r, r2, output logic [3:0] fo, output logic we, pwe);
        logic               b;
        logic [15:0]        a, x;
        logic [16:0]        t;
        logic signed [31:0] m, q, rm;
        b   = i[15] && i[14:12] != OPC_SUB;
        a   = b ? {s[7:0], 8'h00} : s;
        x   = b ? {d[7:0], 8'h00} : d;
        fo  = {3'b000, f[0]};
        we  = 1'b1;
        pwe = 1'b0;
        r   = 16'h0000;
        r2  = 16'h0000;
        case (i[14:12])
            OPC_SUB: begin
                t = {1'b0, x} + {1'b0, ~a} + 17'h0_0001;
                r = t[15:0];
                fo[1:0] = {x[15] != a[15] && r[15] == a[15], ~t[16]};
            end
            OPC_CMP: begin
                t = {1'b0, a} + {1'b0, ~x} + 17'h0_0001;
                r = t[15:0];
                fo[1:0] = {a[15] != x[15] && r[15] == x[15], ~t[16]};
                we = 1'b0;
            end
            OPC_BIT: begin
                r = a & x;
                we = 1'b0;
            end
            OPC_BIC: r = ~a & x;
            OPC_BIS: r = a | x;
            default: begin
                m = {d, p};
                if (i[11:9] == SUB_XOR) r = s ^ d;
                else if (i[11:9] == SUB_MUL) begin
                    m = $signed(d) * $signed(s);
                    r = i[6] ? m[15:0] : m[31:16];
                    r2 = m[15:0];
                    pwe = !i[6];
                    fo = {m < 0, m == 0, 1'b0, m < -32768 || m >= 32767};
                end else if (s == 16'h0000) begin
                    fo = {f[3:2], 2'b11};
                    we = 1'b0;
                end else begin
                    q = m / $signed(s);
                    rm = m % $signed(s);
                    we = q <= 32767 && q >= -32768;
                    pwe = we;
                    r = q[15:0];
                    r2 = rm[15:0];
                    fo = we ? {q < 0, q == 0, 2'b00} : {f[3:2], 2'b10};
                end
            end
        endcase
        if (!(i[15:12] == 4'h7 && i[11:9] != SUB_XOR)) begin
            fo[3:2] = {r[15], r == 16'h0000};
            r = b ? {d[15:8], r[15:8]} : r;
        end
    endfunction : ref_op
    task automatic run_op(input logic [15:0] i, s, d, p, input logic [3:0] f);
        logic [15:0] r, r2;
        logic [3:0]  fo;
        logic        we, pwe;
        ref_op(i, s, d, p, f, r, r2, fo, we, pwe);
        apb(1'b1, OFF_SRC, {16'h0000, s});
        apb(1'b1, OFF_DST, {16'h0000, d});
        apb(1'b1, OFF_PAIR, {16'h0000, p});
        apb(1'b1, OFF_FLAGS, {28'h000_0000, f});
        if (we) wq.push_back(r);
        apb(1'b1, OFF_INSTR, {16'h0000, i});
        if (i[15:12] == 4'h7 && i[11:9] == SUB_DIV) repeat (36) @(posedge pclk);
        rd(OFF_FLAGS, {28'h000_0000, fo});
        if (we) rd(OFF_RESULT, {16'h0000, r});
        if (pwe) rd(OFF_RES_PAIR, {16'h0000, r2});
        rd(OFF_SRC, {16'h0000, s});
    endtask : run_op
    task automatic conclude();
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        conclude();
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h469c_255d));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFF_FLAGS, 32'h0000_0000);
        foreach (dir[k]) run_op(dir[k][63:48], dir[k][47:32], dir[k][31:16], dir[k][15:0],
            4'($urandom));
        for (int k = 0; k < 48; k++) begin
            i = ops[k < 12 ? k : $urandom % 12];
            i = i | (16'($urandom) & (i[15:12] == 4'h7 ? 16'h01bf : 16'h0fff));
            run_op(i, 16'($urandom), 16'($urandom), 16'($urandom), 4'($urandom));
        end
        apb(1'b1, OFF_SRC, 32'h0000_0003);
        apb(1'b1, OFF_DST, 32'h0000_0000);
        apb(1'b1, OFF_PAIR, 32'h0000_0064);
        wq.push_back(16'h0021);
        apb(1'b1, OFF_INSTR, 32'h0000_7200);
        apb(1'b1, OFF_SRC, 32'h0000_7777);
        rd(OFF_STATUS, 32'h0000_0101);
        repeat (36) @(posedge pclk);
        rd(OFF_SRC, 32'h0000_0003);
        apb(1'b1, OFF_RESULT, 32'h0000_ffff);
        rd(OFF_RESULT, 32'h0000_0021);
        rd(8'h20, 32'h0000_0000);
        conclude();
    end
endmodule : testbench
bind doa_alu doa_alu_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wb_dst_we, .wb_pair_we, .wb_dst_reg,
    .pair_successor_register, .wb_dst_data, .wb_pair_data, .cond_flags);
`default_nettype wire
